// File: verilog/acs_pkg.sv
// Package with constants shared by both ends of the amplifier control sequencer.
package acs_pkg;
    localparam int unsigned CLK_HZ = 25000000;
    // Times in their own units, with cycle counts derived from the clock rate.
    localparam int unsigned T_VALID_LOW_RST_NS = 300;
    localparam int unsigned T_RST_PULSE_MS = 1;
    localparam int unsigned T_PORT_READY_US = 3500;
    localparam int unsigned T_RUN_MS = 10;
    localparam int unsigned T_VALID_LOW_PDN_US = 725;
    localparam int unsigned T_STARTUP_MS = 120;
    localparam int unsigned T_PDN_PULSE_NS = 800;
    localparam int unsigned T_FAULT_LOW_NS = 350;
    localparam int unsigned T_HEADPHONE_SELECT_PULSE_NS = 350;
    localparam int unsigned NS_PER_S = 1000000000;
    localparam int unsigned CYC_VALID_LOW_RST = T_VALID_LOW_RST_NS * (CLK_HZ / 1000000) / 1000;
    localparam int unsigned CYC_RST_PULSE = T_RST_PULSE_MS * (CLK_HZ / 1000);
    localparam int unsigned CYC_PORT_READY = T_PORT_READY_US * (CLK_HZ / 1000000);
    localparam int unsigned CYC_RUN = T_RUN_MS * (CLK_HZ / 1000);
    localparam int unsigned CYC_VALID_LOW_PDN = T_VALID_LOW_PDN_US * (CLK_HZ / 1000000);
    localparam int unsigned CYC_STARTUP = T_STARTUP_MS * (CLK_HZ / 1000);
    localparam int unsigned CYC_PDN_PULSE =
        (T_PDN_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    localparam int unsigned CYC_FAULT_LOW = T_FAULT_LOW_NS * (CLK_HZ / 1000000) / 1000;
    localparam int unsigned CYC_HEADPHONE_SELECT_PULSE =
        (T_HEADPHONE_SELECT_PULSE_NS * (CLK_HZ / 1000000) + 999) / 1000;
    // Volume ramp step sizes in frame clocks, per rate class.
    localparam logic [4:0] STEP_LR_NORMAL = 5'h04;
    localparam logic [4:0] STEP_LR_DOUBLE = 5'h08;
    localparam logic [4:0] STEP_LR_QUAD = 5'h10;
    localparam logic [10:0] RAMP_STEPS_RESET = 11'h400;
    localparam logic [1:0] RATE_NORMAL = 2'h0;
    localparam logic [1:0] RATE_DOUBLE = 2'h1;
    localparam logic [1:0] RATE_QUAD = 2'h2;
    // Fault recovery hold time in milliseconds, reset value.
    localparam logic [7:0] FAULT_HOLD_MS_RESET = 8'h01;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    // Controller register offsets on APB.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CFG = 8'h04;
    localparam logic [7:0] REG_STATUS = 8'h08;
    // Control register fields.
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_PDN_BIT = 1;
    localparam int CTRL_MUTE_BIT = 2;
    localparam int CTRL_HEADPHONE_SELECT_BIT = 3;
    localparam int CTRL_START_BIT = 4;
    localparam int CTRL_HPDIS_BIT = 5;
    // Configuration register fields.
    localparam int CFG_STEPS_LSB = 0;
    localparam int CFG_RATE_LSB = 12;
    localparam int CFG_HOLD_LSB = 16;
    // Status register fields.
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_PORT_READY_BIT = 1;
    localparam int ST_RUNNING_BIT = 2;
    localparam int ST_VALID_BIT = 3;
    localparam int ST_SPK_LOW_BIT = 4;
    localparam int ST_MUTED_BIT = 5;
    localparam int ST_HP_EN_BIT = 6;
    localparam int ST_FAULT_BIT = 7;
endpackage

// File: verilog/acs_if.sv
// Interface joining the controller end and the amplifier end.
`timescale 1ns/1ps
interface acs_if;
    logic reset_n;
    logic power_down_n;
    logic mute_n;
    logic headphone_select;
    logic start_cmd;
    logic hp_disable;
    logic [10:0] ramp_steps;
    logic [1:0] rate_class;
    logic [7:0] fault_hold_ms;
    logic port_ready;
    logic running;
    logic valid;
    logic speaker_low;
    logic muted;
    logic headphone_pwm_out;
    modport ctrl (
        output reset_n, power_down_n, mute_n, headphone_select, start_cmd, hp_disable,
        output ramp_steps, rate_class, fault_hold_ms,
        input port_ready, running, valid, speaker_low, muted, headphone_pwm_out
    );
    modport amp (
        input reset_n, power_down_n, mute_n, headphone_select, start_cmd, hp_disable,
        input ramp_steps, rate_class, fault_hold_ms,
        output port_ready, running, valid, speaker_low, muted, headphone_pwm_out
    );
endinterface

// File: verilog/acs_sync.sv
// Two-flop synchroniser for a level arriving from outside the clock domain.
`timescale 1ns/1ps
module acs_sync (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic rst_val,
    input wire logic d,
    output logic q
);
    logic meta_q;
    logic sync_q;

    // Flops hold the departure from the idle level rst_val, so reset shows no false edge.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
        end
        else
        begin
            meta_q <= d ^ rst_val;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q ^ rst_val;
endmodule

// File: verilog/acs_amp.sv
// Amplifier end: reset, power-down, fault, mute ramp and headphone sequencing.
// Overview of operation
// R1: Reset drives power-stage enable low quickly.
// R2: Controller holds reset about 1 ms.
// R3: Control port ready 3.5 ms after reset.
// R4: Allow 10 ms after start-up command.
// R5: Reset ignored while powered down.
// R6: Power-down ignored while held in reset.
// R7: Power-down drops enable; 120 ms start-up.
// R8: Power-down held at least 800 ns.
// R9: Fault input low at least 350 ns; the fault pin is only synchronised, with no minimum-width filter.
// R10: Fault forces speaker outputs low fast.
// R11: Hold low programmed time, exit when clear.
// R12: Mute ramp lasts steps times step size.
// R13: Step size 4, 8 or 16 frames.
// R14: Headphone select held at least 350 ns; the controller drives it straight from its bit, untimed.
// R15: Disable bit gates headphone output on select.
// R16: Mute input ramps volume down and up.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module acs_amp (
    input wire logic pclk,
    input wire logic presetn,
    acs_if.amp link,
    input wire logic lrclk,
    input wire logic backend_fault_n,
    output logic [10:0] volume_step,
    output logic spk_out_low
);
    typedef enum logic [2:0] {
        ACS_ST_RESET, ACS_ST_BOOT, ACS_ST_IDLE, ACS_ST_STARTING, ACS_ST_RUN,
        ACS_ST_PDN_FALL, ACS_ST_PDN, ACS_ST_WAKE
    } acs_state_e;

    acs_state_e state_q;
    logic [22:0] tmr_q;
    logic rst_s;
    logic pdn_s;
    logic fault_s;
    logic rst_n_s;
    logic pdn_n_s;
    logic fault_n_s;
    logic headphone_select_s;
    logic lr_s;
    logic lr_d1_q;
    logic lr_rise;
    logic valid_q;
    logic port_ready_q;
    logic running_q;
    logic spk_low_q;
    logic muted_q;
    logic hp_q;
    logic [10:0] vol_q;
    logic [4:0] frm_q;
    logic [4:0] step_len;
    logic fault_hold_q;
    logic [22:0] ftmr_q;
    logic [7:0] fms_q;

    // Reset, power-down, fault, headphone select and frame clock are synchronised; active-low pins rest at their idle high level.
    acs_sync u_rst (.pclk(pclk), .presetn(presetn), .rst_val(1'b1),
        .d(link.reset_n), .q(rst_n_s));
    acs_sync u_pdn (.pclk(pclk), .presetn(presetn), .rst_val(1'b1),
        .d(link.power_down_n), .q(pdn_n_s));
    acs_sync u_flt (.pclk(pclk), .presetn(presetn), .rst_val(1'b1),
        .d(backend_fault_n), .q(fault_n_s));
    assign rst_s = !rst_n_s;
    assign pdn_s = !pdn_n_s;
    assign fault_s = !fault_n_s;
    acs_sync u_hps (.pclk(pclk), .presetn(presetn), .rst_val(1'b0),
        .d(link.headphone_select), .q(headphone_select_s));
    acs_sync u_lrc (.pclk(pclk), .presetn(presetn), .rst_val(1'b0),
        .d(lrclk), .q(lr_s));

    // Frame-clock rising edge detection works on the synchronised level.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            lr_d1_q <= 1'b0;
        else
            lr_d1_q <= lr_s;
    end
    assign lr_rise = lr_s & ~lr_d1_q;

    // Step length follows the programmed rate class.
    always_comb
    begin
        unique case (link.rate_class)
            acs_pkg::RATE_DOUBLE: step_len = acs_pkg::STEP_LR_DOUBLE; // [R13]
            acs_pkg::RATE_QUAD: step_len = acs_pkg::STEP_LR_QUAD; // [R13]
            default: step_len = acs_pkg::STEP_LR_NORMAL; // [R13]
        endcase
    end

    // Power sequencing: reset, port bring-up, start-up, power-down and wake.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_q <= ACS_ST_RESET;
            tmr_q <= 23'h000000;
        end
        else if (rst_s && state_q != ACS_ST_PDN) // [R5]
        begin
            state_q <= ACS_ST_RESET; // [R1]
            tmr_q <= 23'h000000;
        end
        else
        begin
            tmr_q <= tmr_q + 23'h000001;
            unique case (state_q)
                ACS_ST_RESET:
                begin
                    state_q <= ACS_ST_BOOT; // [R6]
                    tmr_q <= 23'h000000;
                end
                ACS_ST_BOOT:
                    if (tmr_q >= 23'(acs_pkg::CYC_PORT_READY - 1)) // [R3]
                    begin
                        state_q <= ACS_ST_IDLE;
                        tmr_q <= 23'h000000;
                    end
                ACS_ST_IDLE:
                    if (pdn_s)
                    begin
                        state_q <= ACS_ST_PDN_FALL;
                        tmr_q <= 23'h000000;
                    end
                    else if (link.start_cmd)
                    begin
                        state_q <= ACS_ST_STARTING;
                        tmr_q <= 23'h000000;
                    end
                ACS_ST_STARTING:
                    if (pdn_s)
                    begin
                        state_q <= ACS_ST_PDN_FALL;
                        tmr_q <= 23'h000000;
                    end
                    else if (tmr_q >= 23'(acs_pkg::CYC_RUN - 1)) // [R4]
                        state_q <= ACS_ST_RUN;
                ACS_ST_RUN:
                    if (pdn_s)
                    begin
                        state_q <= ACS_ST_PDN_FALL;
                        tmr_q <= 23'h000000;
                    end
                ACS_ST_PDN_FALL:
                    if (tmr_q >= 23'(acs_pkg::CYC_VALID_LOW_PDN - 1)) // [R7]
                        state_q <= ACS_ST_PDN;
                ACS_ST_PDN:
                    if (!pdn_s)
                    begin
                        state_q <= ACS_ST_WAKE;
                        tmr_q <= 23'h000000;
                    end
                ACS_ST_WAKE:
                    if (tmr_q >= 23'(acs_pkg::CYC_STARTUP - 1)) // [R7]
                        state_q <= ACS_ST_RUN;
            endcase
        end
    end

    // Status flags derived from the sequencing state.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            valid_q <= 1'b0;
            port_ready_q <= 1'b0;
            running_q <= 1'b0;
        end
        else
        begin
            valid_q <= (state_q == ACS_ST_RUN) && !rst_s && !pdn_s; // [R1] [R7]
            port_ready_q <= state_q inside {ACS_ST_IDLE, ACS_ST_STARTING, ACS_ST_RUN,
                ACS_ST_PDN_FALL, ACS_ST_PDN, ACS_ST_WAKE}; // [R3]
            running_q <= (state_q == ACS_ST_RUN);
        end
    end

    // Fault shutdown: speaker outputs low at once, hold, then retry if clear.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            fault_hold_q <= 1'b0;
            ftmr_q <= 23'h000000;
            fms_q <= 8'h00;
            spk_low_q <= 1'b1;
        end
        else
        begin
            if (fault_s)
            begin
                fault_hold_q <= 1'b1; // [R10]
                ftmr_q <= 23'h000000;
                fms_q <= 8'h00;
            end
            else if (fault_hold_q)
            begin
                if (ftmr_q >= 23'(acs_pkg::CYC_PER_MS - 1))
                begin
                    ftmr_q <= 23'h000000;
                    fms_q <= fms_q + 8'h01;
                end
                else
                    ftmr_q <= ftmr_q + 23'h000001;
                if (fms_q >= link.fault_hold_ms)
                    fault_hold_q <= 1'b0; // [R11]
            end
            spk_low_q <= fault_s || fault_hold_q || !valid_q; // [R10] [R11]
        end
    end

    // Volume ramp: one step per step length of frame clocks toward the target, or a jump down to it when unmuted above it.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vol_q <= 11'h000;
            frm_q <= 5'h00;
            muted_q <= 1'b1;
        end
        else
        begin
            if (lr_rise)
            begin
                if (frm_q >= step_len - 5'h01) // [R13]
                begin
                    frm_q <= 5'h00;
                    if (!link.mute_n && vol_q != 11'h000)
                        vol_q <= vol_q - 11'h001; // [R16]
                    else if (link.mute_n && vol_q < link.ramp_steps)
                        vol_q <= vol_q + 11'h001; // [R12] [R16]
                    else if (vol_q > link.ramp_steps)
                        vol_q <= link.ramp_steps;
                end
                else
                    frm_q <= frm_q + 5'h01;
            end
            muted_q <= (vol_q == 11'h000);
        end
    end

    // Headphone output is on only while running, and is disabled while select is low only when the disable bit is set.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hp_q <= 1'b0;
        else
            hp_q <= running_q && !(link.hp_disable && !headphone_select_s); // [R15]
    end

    assign link.valid = valid_q;
    assign link.port_ready = port_ready_q;
    assign link.running = running_q;
    assign link.speaker_low = spk_low_q;
    assign link.muted = muted_q;
    assign link.headphone_pwm_out = hp_q;
    assign volume_step = vol_q;
    assign spk_out_low = spk_low_q;
endmodule

// File: verilog/acs_ctrl.sv
// Controller end: APB registers that drive the control pins and report status.
`timescale 1ns/1ps
module acs_ctrl (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    acs_if.ctrl link
);
    logic [5:0] ctrl_q;
    logic [23:0] cfg_q;
    logic [7:0] st_q;
    logic [31:0] rd_q;
    logic rdy_q;
    logic err_q;
    logic [22:0] rtmr_q;
    logic [4:0] pdn_tmr_q;
    logic start_q;
    logic setup;
    logic hit;

    assign setup = psel && !penable;
    assign hit = paddr == acs_pkg::REG_CTRL || paddr == acs_pkg::REG_CFG ||
        paddr == acs_pkg::REG_STATUS;

    // APB slave answers one cycle after the setup cycle; unmapped gives an error.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rdy_q <= 1'b0;
            err_q <= 1'b0;
            rd_q <= 32'h00000000;
        end
        else
        begin
            rdy_q <= setup;
            err_q <= setup && !hit;
            rd_q <= 32'h00000000;
            if (setup && !pwrite)
            begin
                unique case (paddr)
                    acs_pkg::REG_CTRL: rd_q <= {26'h0000000, ctrl_q};
                    acs_pkg::REG_CFG: rd_q <= {8'h00, cfg_q};
                    acs_pkg::REG_STATUS: rd_q <= {24'h000000, st_q};
                    default: rd_q <= 32'h00000000;
                endcase
            end
        end
    end

    // Register writes, reset pulse timing and one-cycle start command.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_q <= 6'h02;
            cfg_q <= {acs_pkg::FAULT_HOLD_MS_RESET, 2'h0, acs_pkg::RATE_NORMAL, 1'b0,
                acs_pkg::RAMP_STEPS_RESET};
            rtmr_q <= 23'h000000;
            start_q <= 1'b0;
            pdn_tmr_q <= 5'h00;
        end
        else
        begin
            start_q <= 1'b0;
            if (rtmr_q != 23'h000000)
                rtmr_q <= rtmr_q - 23'h000001; // [R2]
            if (pdn_tmr_q != 5'h00)
                pdn_tmr_q <= pdn_tmr_q - 5'h01; // [R8]
            if (psel && penable && rdy_q && pwrite)
            begin
                if (paddr == acs_pkg::REG_CTRL)
                begin
                    ctrl_q <= pwdata[5:0];
                    if (pwdata[acs_pkg::CTRL_RESET_BIT])
                        rtmr_q <= 23'(acs_pkg::CYC_RST_PULSE); // [R2]
                    if (!pwdata[acs_pkg::CTRL_PDN_BIT] && ctrl_q[acs_pkg::CTRL_PDN_BIT])
                        pdn_tmr_q <= 5'(acs_pkg::CYC_PDN_PULSE); // [R8]
                    if (pwdata[acs_pkg::CTRL_START_BIT] && st_q[acs_pkg::ST_PORT_READY_BIT])
                        start_q <= 1'b1; // [R3] [R4]
                end
                else if (paddr == acs_pkg::REG_CFG)
                    cfg_q <= pwdata[23:0];
            end
        end
    end

    // Status capture from the amplifier end, with the busy bit taken from the reset pulse timer.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            st_q <= 8'h00;
        else
            st_q <= {1'b0, link.headphone_pwm_out, link.muted, link.speaker_low, link.valid,
                link.running, link.port_ready, (rtmr_q != 23'h000000)};
    end

    assign prdata = rd_q;
    assign pready = rdy_q;
    assign pslverr = err_q;
    // Pins: reset held for the full pulse, power-down held its least width.
    assign link.reset_n = !(rtmr_q != 23'h000000); // [R2]
    assign link.power_down_n = ctrl_q[acs_pkg::CTRL_PDN_BIT] && pdn_tmr_q == 5'h00; // [R8]
    assign link.mute_n = !ctrl_q[acs_pkg::CTRL_MUTE_BIT];
    assign link.headphone_select = ctrl_q[acs_pkg::CTRL_HEADPHONE_SELECT_BIT]; // [R14]
    assign link.start_cmd = start_q;
    assign link.hp_disable = ctrl_q[acs_pkg::CTRL_HPDIS_BIT];
    assign link.ramp_steps = cfg_q[10:0];
    assign link.rate_class = cfg_q[13:12];
    assign link.fault_hold_ms = cfg_q[23:16];
endmodule

// File: dv/acs_props.sv
// Checker of the sequencing rules seen on the link between the two ends.
`timescale 1ns/1ps
module acs_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic reset_n,
    input wire logic power_down_n,
    input wire logic headphone_select,
    input wire logic start_cmd,
    input wire logic hp_disable,
    input wire logic [1:0] rate_class,
    input wire logic port_ready,
    input wire logic running,
    input wire logic valid,
    input wire logic headphone_pwm_out,
    input wire logic lrclk,
    input wire logic backend_fault_n,
    input wire logic [10:0] volume_step,
    input wire logic spk_out_low
);
    localparam int PORT_CYC = acs_pkg::CYC_PORT_READY;
    localparam int RUN_CYC = acs_pkg::CYC_RUN;
    logic lr_q;
    int frm_q;
    int port_q;
    int run_q;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // Counts frame clock rises since the last volume step.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lr_q <= 1'b0;
            frm_q <= 0;
        end
        else
        begin
            lr_q <= lrclk;
            if ($changed(volume_step))
                frm_q <= 0;
            else if (lrclk && !lr_q && frm_q < 1000)
                frm_q <= frm_q + 1;
        end
    end
    // Counts cycles since the amplifier last left reset.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            port_q <= 0;
        else if (!reset_n)
            port_q <= 0;
        else if (port_q < PORT_CYC + 10)
            port_q <= port_q + 1;
    end
    // Counts cycles since the last start command.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            run_q <= 0;
        else if (start_cmd)
            run_q <= 0;
        else if (run_q < RUN_CYC + 10)
            run_q <= run_q + 1;
    end
    sequence fault_edge;
        $fell(backend_fault_n);
    endsequence
    sequence hp_pull;
        $fell(headphone_select) && hp_disable;
    endsequence
    // Timing and ordering relations between the two ends.
    a_reset_valid: assert property ($fell(reset_n) |-> ##[0:8] !valid)
        else $error("power stage enable stayed high after reset");
    a_port_wait: assert property ($rose(port_ready) |-> port_q >= PORT_CYC - 1)
        else $error("control port ready too early");
    a_run_wait: assert property ($rose(running) |-> run_q >= RUN_CYC - 1)
        else $error("running too soon after start");
    a_pdn_valid: assert property ($fell(power_down_n) && valid && reset_n |-> ##[1:4] !valid)
        else $error("power stage enable stayed high after power-down");
    a_fault_low: assert property (fault_edge |-> ##[0:4] spk_out_low)
        else $error("speaker outputs not forced low on fault");
    a_fault_hold: assert property (spk_out_low && !backend_fault_n |=> spk_out_low)
        else $error("speaker outputs released while fault present");
    a_ramp_one: assert property ($changed(volume_step) |->
        volume_step == $past(volume_step) + 11'h001 || volume_step == $past(volume_step) - 11'h001)
        else $error("volume moved by more than one step");
    a_ramp_step: assert property ($changed(volume_step) |-> frm_q >= (4 << rate_class) - 1)
        else $error("volume step came too early");
    a_hp_disable: assert property (hp_pull |-> ##[0:4] !headphone_pwm_out)
        else $error("headphone output not disabled");
    a_hp_keep: assert property ($fell(headphone_select) && !hp_disable && headphone_pwm_out
        |=> headphone_pwm_out)
        else $error("headphone output dropped with disable clear");
endmodule

// File: dv/amp_control_sequencer_tb_top.sv
// Testbench joining the controller and amplifier ends and driving them over APB.
`timescale 1ns/1ps
module amp_control_sequencer_tb_top;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic lrclk;
    logic lr_en;
    logic [1:0] lr_div;
    logic backend_fault_n;
    logic [10:0] volume_step;
    logic spk_out_low;
    logic [31:0] rd;
    logic err;
    int bad_count;
    int total_checks;
    int cyc_cnt;
    int r;
    int span;
    int k;
    acs_if link();
    acs_ctrl u_acs_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .link(link.ctrl));
    acs_amp u_acs_amp (.pclk(pclk), .presetn(presetn), .link(link.amp), .lrclk(lrclk),
        .backend_fault_n(backend_fault_n), .volume_step(volume_step),
        .spk_out_low(spk_out_low));
    acs_props u_acs_props (.pclk(pclk), .presetn(presetn), .reset_n(link.reset_n),
        .power_down_n(link.power_down_n), .headphone_select(link.headphone_select),
        .start_cmd(link.start_cmd), .hp_disable(link.hp_disable),
        .rate_class(link.rate_class), .port_ready(link.port_ready), .running(link.running),
        .valid(link.valid), .headphone_pwm_out(link.headphone_pwm_out), .lrclk(lrclk),
        .backend_fault_n(backend_fault_n), .volume_step(volume_step),
        .spk_out_low(spk_out_low));
    // Clock of 40 ns period.
    always #20 pclk = ~pclk;
    // Frame clock of eight cycles per frame while enabled, and cycles since reset.
    always @(posedge pclk)
    begin
        cyc_cnt <= presetn ? cyc_cnt + 1 : 0;
        lr_div <= lr_en ? lr_div + 2'h1 : 2'h0;
        if (!lr_en)
            lrclk <= 1'b0;
        else if (lr_div == 2'h3)
            lrclk <= ~lrclk;
    end
    // Prints the counts and the verdict, then ends the run.
    task report_and_stop;
        $display("Checks made: %0d, mismatches: %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Compares one value against its expectation.
    task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp)
        begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            bad_count++;
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high.
    task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1)
        begin
            $display("[FAIL] pready expected 1 seen %b", pready);
            bad_count++;
            report_and_stop;
        end
        else
        begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    // Reads a register and compares the masked word.
    task rd_chk(input string name, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(name, e, rd & m);
    endtask
    // Main sequence.
    initial
    begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        backend_fault_n = 1'b1;
        lr_en = 1'b0;
        lrclk = 1'b0;
        lr_div = 2'h0;
        bad_count = 0;
        total_checks = 0;
        cyc_cnt = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd_chk("cfg_reset", acs_pkg::REG_CFG, 32'hFFFF_FFFF, 32'h0001_0400);
        rd_chk("status_boot", acs_pkg::REG_STATUS, 32'h0000_0016, 32'h0000_0010);
        apb(1'b0, 8'h0C, 32'h0000_0000);
        chk("unmapped_err", 32'h0000_0001, {31'h0, err});
        apb(1'b1, acs_pkg::REG_CFG, 32'h0001_0008);
        rd_chk("cfg_rw", acs_pkg::REG_CFG, 32'hFFFF_FFFF, 32'h0001_0008);
        lr_en <= 1'b1;
        // Unmute and mute ramps of eight steps at each rate class.
        for (r = 0; r < 3; r++)
        begin
            span = 8 * (4 << r) * 8;
            apb(1'b1, acs_pkg::REG_CFG, 32'h0001_0008 | (r << 12));
            apb(1'b1, acs_pkg::REG_CTRL, 32'h0000_0002);
            repeat (span * 3 / 4) @(posedge pclk);
            chk("vol_mid", 32'h0000_0001, {31'h0, volume_step < 11'h008});
            repeat (span / 4 + 40) @(posedge pclk);
            chk("vol_up", 32'h0000_0008, {21'h0, volume_step});
            apb(1'b1, acs_pkg::REG_CTRL, 32'h0000_0006);
            repeat (span + 40) @(posedge pclk);
            chk("vol_down", 32'h0000_0000, {21'h0, volume_step});
        end
        backend_fault_n <= 1'b0;
        repeat (10) @(posedge pclk);
        chk("spk_low", 32'h0000_0001, {31'h0, spk_out_low});
        backend_fault_n <= 1'b1;
        apb(1'b1, acs_pkg::REG_CTRL, 32'h0000_002A);
        apb(1'b1, acs_pkg::REG_CTRL, 32'h0000_0022);
        rd_chk("hp_off", acs_pkg::REG_STATUS, 32'h0000_0040, 32'h0000_0000);
        while (cyc_cnt < acs_pkg::CYC_PORT_READY - 20) @(posedge pclk);
        rd_chk("port_early", acs_pkg::REG_STATUS, 32'h0000_0002, 32'h0000_0000);
        for (k = 0; k < 100; k++)
        begin
            apb(1'b0, acs_pkg::REG_STATUS, 32'h0000_0000);
            if (rd[1] === 1'b1)
                break;
        end
        chk("port_ready", 32'h0000_0002, rd & 32'h0000_0002);
        apb(1'b1, acs_pkg::REG_CTRL, 32'h0000_0012);
        repeat (1000) @(posedge pclk);
        rd_chk("run_wait", acs_pkg::REG_STATUS, 32'h0000_0004, 32'h0000_0000);
        apb(1'b1, acs_pkg::REG_CTRL, 32'h0000_0003);
        repeat (20) @(posedge pclk);
        rd_chk("reset_busy", acs_pkg::REG_STATUS, 32'h0000_000B, 32'h0000_0001);
        report_and_stop;
    end
endmodule
